// ---- rtl/flash_erase_host.sv ----
// Host controller issuing erase, suspend and program sequences and polling
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
module flash_erase_host
    import flash_host_pkg::*;
#(
    parameter int LOAD_WINDOW = flash_host_pkg::LOAD_WINDOW_CYC
) (
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst_n,
    // APB slave
    input  wire flash_host_pkg::apb_req_t   i_apb,
    output flash_host_pkg::apb_rsp_t        o_apb,
    // Flash pins
    output flash_host_pkg::flash_out_t      o_flash,
    input  wire logic [15:0]                i_flash_dq,
    input  wire logic                       i_ready_busy_n
);
    import flash_host_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [16:0] pins_s;

    flash_pin_sync #(.W(17)) flash_pin_sync_inst (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_pin     ({i_ready_busy_n, i_flash_dq}),
        .o_sync    (pins_s)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_WSETUP = 6'b000010,
        ST_WLOW   = 6'b000100,
        ST_WHIGH  = 6'b001000,
        ST_RLOW   = 6'b010000,
        ST_REVAL  = 6'b100000
    } state_t;

    state_t      state_q, state_d;
    cmd_t        cmd_q, cmd_d;
    logic [2:0]  step_q, step_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [15:0] win_q, win_d;
    logic [21:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [15:0] rd_q, rd_d;
    logic [15:0] prev_q, prev_d;
    logic        first_q, first_d;
    logic        final_q, final_d;
    logic        q5_q, q5_d;
    logic        done_q, done_d;
    logic        tmo_q, tmo_d;
    logic        ref_q, ref_d;
    flash_out_t  fl_q, fl_d;
    logic [31:0] prdata_q, prdata_d;

    // ------------------------------------------------------------------
    // Command step table
    // ------------------------------------------------------------------
    function automatic logic [37:0] step_word(cmd_t c, logic [2:0] s,
                                              logic [21:0] a,
                                              logic [15:0] d);
        logic [37:0] w;
        w = {a, CODE_RESET};
        unique case (c)
            CMD_PROGRAM: begin
                unique case (s)
                    3'h0:    w = {UNLOCK_A1, UNLOCK_D1};
                    3'h1:    w = {UNLOCK_A2, UNLOCK_D2};
                    3'h2:    w = {UNLOCK_A1, CODE_PROGRAM};
                    default: w = {a, d};
                endcase
            end
            CMD_ERASE: begin
                unique case (s)
                    3'h0, 3'h3: w = {UNLOCK_A1, UNLOCK_D1};
                    3'h1, 3'h4: w = {UNLOCK_A2, UNLOCK_D2};
                    3'h2:       w = {UNLOCK_A1, CODE_ERASE_SETUP};
                    default:    w = {a, CODE_SECTOR};
                endcase
            end
            CMD_ADD_SECTOR: w = {a, CODE_SECTOR};
            CMD_SUSPEND:    w = {a, CODE_SUSPEND};
            CMD_RESUME:     w = {a, CODE_RESUME};
            default:        w = {a, CODE_RESET};
        endcase
        return w;
    endfunction

    logic [2:0]  last_step;
    logic [37:0] sw;
    logic        acc_wr, acc_rd, win_open;
    cmd_t        new_cmd;

    assign last_step = (cmd_q == CMD_PROGRAM) ? 3'h3 :
                       (cmd_q == CMD_ERASE)   ? 3'h5 : 3'h0;
    assign sw      = step_word(cmd_q, step_q, addr_q, wdata_q);
    assign acc_wr  = i_apb.psel & i_apb.penable & i_apb.pwrite;
    assign acc_rd  = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
    assign new_cmd = cmd_t'(i_apb.pwdata[3:0]);
    assign win_open = 32'(win_q) + 32'(2) < 32'(LOAD_WINDOW);

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    logic mapped;
    assign mapped = i_apb.paddr inside {OFS_CTRL, OFS_ADDR, OFS_WDATA,
                                        OFS_STATUS, OFS_RDATA};
    // One driver for the whole answer struct
    assign o_apb = '{pready:  i_apb.psel & i_apb.penable,
                     pslverr: i_apb.psel & i_apb.penable & ~mapped,
                     prdata:  prdata_q};
    assign o_flash       = fl_q;

    always_comb begin
        prdata_d = prdata_q;
        if (acc_rd) begin
            prdata_d = 32'h0;
            unique case (i_apb.paddr)
                OFS_CTRL:   prdata_d = {28'h0, cmd_q};
                OFS_ADDR:   prdata_d = {10'h0, addr_q};
                OFS_WDATA:  prdata_d = {16'h0, wdata_q};
                OFS_STATUS: begin
                    prdata_d[ST_BIT_BUSY]    = state_q != ST_IDLE;
                    prdata_d[ST_BIT_DONE]    = done_q;
                    prdata_d[ST_BIT_TIMEOUT] = tmo_q;
                    prdata_d[ST_BIT_REFUSED] = ref_q;
                    prdata_d[ST_BIT_READY]   = pins_s[16];
                    prdata_d[ST_BIT_POLL]    = rd_q[DQ_POLL];
                    prdata_d[ST_BIT_WINDOW]  = rd_q[DQ_WINDOW];
                end
                OFS_RDATA:  prdata_d = {16'h0, rd_q};
                default:    prdata_d = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cmd_d   = cmd_q;
        step_d  = step_q;
        cnt_d   = cnt_q;
        win_d   = (win_q == 16'hffff) ? win_q : win_q + 16'h1;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rd_d    = rd_q;
        prev_d  = prev_q;
        first_d = first_q;
        final_d = final_q;
        q5_d    = q5_q;
        done_d  = done_q;
        tmo_d   = tmo_q;
        ref_d   = ref_q;
        fl_d    = fl_q;
        if (acc_wr && i_apb.paddr == OFS_ADDR && state_q == ST_IDLE)
            addr_d = i_apb.pwdata[21:0];
        if (acc_wr && i_apb.paddr == OFS_WDATA && state_q == ST_IDLE)
            wdata_d = i_apb.pwdata[15:0];
        unique case (state_q)
            ST_IDLE: begin
                fl_d = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                         addr: addr_q, dq: 16'h0, dq_oe: 1'b0};
                if (acc_wr && i_apb.paddr == OFS_CTRL) begin
                    done_d  = 1'b0;
                    tmo_d   = 1'b0;
                    ref_d   = 1'b0;
                    cmd_d   = new_cmd;
                    step_d  = 3'h0;
                    first_d = 1'b1;
                    q5_d    = 1'b0;
                    final_d = new_cmd == CMD_READ;
                    if (new_cmd == CMD_ADD_SECTOR && !win_open)
                        ref_d = 1'b1;
                    else if (new_cmd == CMD_READ || new_cmd == CMD_POLL)
                        state_d = ST_RLOW;
                    else if (new_cmd != CMD_NONE && new_cmd <= CMD_RESET)
                        state_d = ST_WSETUP;
                    cnt_d = 8'h0;
                end
            end
            ST_WSETUP: begin
                // Address and code set before strobes
                fl_d.addr  = sw[37:16];
                fl_d.dq    = sw[15:0];
                fl_d.dq_oe = 1'b1;
                state_d    = ST_WLOW;
            end
            ST_WLOW: begin
                fl_d.ce_n = 1'b0;
                fl_d.we_n = 1'b0;
                cnt_d     = cnt_q + 8'h1;
                if (32'(cnt_q) + 1 >= WE_LOW_CYC) begin
                    state_d   = ST_WHIGH;
                    cnt_d     = 8'h0;
                    fl_d.ce_n = 1'b1;
                    fl_d.we_n = 1'b1;
                    if (step_q == last_step && (cmd_q == CMD_ERASE ||
                        cmd_q == CMD_ADD_SECTOR))
                        win_d = 16'h0;
                end
            end
            ST_WHIGH: begin
                cnt_d = cnt_q + 8'h1;
                if (32'(cnt_q) + 1 >= WE_HIGH_CYC) begin
                    cnt_d      = 8'h0;
                    fl_d.dq_oe = 1'b0;
                    if (step_q == last_step) begin
                        state_d = ST_IDLE;
                        done_d  = 1'b1;
                    end else begin
                        step_d  = step_q + 3'h1;
                        state_d = ST_WSETUP;
                    end
                end
            end
            ST_RLOW: begin
                // Status read at the held address
                fl_d.addr = addr_q;
                fl_d.ce_n = 1'b0;
                fl_d.oe_n = 1'b0;
                cnt_d     = cnt_q + 8'h1;
                if (32'(cnt_q) + 1 >= READ_CYC) begin
                    rd_d      = pins_s[15:0];
                    cnt_d     = 8'h0;
                    fl_d.ce_n = 1'b1;
                    fl_d.oe_n = 1'b1;
                    state_d   = ST_REVAL;
                end
            end
            ST_REVAL: begin
                state_d = ST_RLOW;
                prev_d  = rd_q;
                first_d = 1'b0;
                // Data kept from read after completion
                if (final_q) begin
                    state_d = ST_IDLE;
                    done_d  = 1'b1;
                end else if (first_q) begin
                    first_d = 1'b0;
                // Toggle steady over two reads ends poll
                end else if (rd_q[DQ_TOGGLE1] == prev_q[DQ_TOGGLE1]) begin
                    final_d = 1'b1;
                end else if (q5_q) begin
                    state_d = ST_IDLE;
                    tmo_d   = 1'b1;
                end else begin
                    q5_d = rd_q[DQ_TIMEOUT];
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q  <= ST_IDLE;
            cmd_q    <= CMD_NONE;
            step_q   <= 3'h0;
            cnt_q    <= 8'h0;
            win_q    <= 16'hffff;
            addr_q   <= ADDR_RST;
            wdata_q  <= WDATA_RST;
            rd_q     <= 16'h0;
            prev_q   <= 16'h0;
            first_q  <= 1'b0;
            final_q  <= 1'b0;
            q5_q     <= 1'b0;
            done_q   <= 1'b0;
            tmo_q    <= 1'b0;
            ref_q    <= 1'b0;
            fl_q     <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                          addr: 22'h0, dq: 16'h0, dq_oe: 1'b0};
            prdata_q <= 32'h0;
        end else begin
            state_q  <= state_d;
            cmd_q    <= cmd_d;
            step_q   <= step_d;
            cnt_q    <= cnt_d;
            win_q    <= win_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            rd_q     <= rd_d;
            prev_q   <= prev_d;
            first_q  <= first_d;
            final_q  <= final_d;
            q5_q     <= q5_d;
            done_q   <= done_d;
            tmo_q    <= tmo_d;
            ref_q    <= ref_d;
            fl_q     <= fl_d;
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_erase_setup_code: assert property (
        (!fl_q.we_n && cmd_q == CMD_ERASE && step_q == 3'h2)
        |-> fl_q.dq == CODE_ERASE_SETUP && fl_q.addr == UNLOCK_A1)
        else $error("erase setup write not 80H at unlock address");
    a_erase_sector_code: assert property (
        (!fl_q.we_n && cmd_q == CMD_ERASE && step_q == 3'h5)
        |-> fl_q.dq == CODE_SECTOR && fl_q.addr == addr_q)
        else $error("sector erase write not 30H at sector address");
    a_write_data_held: assert property (
        $rose(fl_q.we_n) |-> fl_q.dq_oe && $stable(fl_q.dq))
        else $error("write data not held across strobe rise");
    a_load_in_window: assert property (
        $fell(fl_q.we_n) && cmd_q == CMD_ADD_SECTOR
        |-> 32'($past(win_q)) < 32'(LOAD_WINDOW))
        else $error("sector load started after window");
    a_poll_steady_end: assert property (
        (state_q == ST_REVAL && !final_q && !first_q
         && rd_q[DQ_TOGGLE1] == prev_q[DQ_TOGGLE1])
        |=> final_q && state_q == ST_RLOW)
        else $error("steady toggle did not end polling");
    a_poll_at_address: assert property (
        !fl_q.oe_n |-> fl_q.addr == addr_q && fl_q.we_n)
        else $error("status read away from held address");
    a_done_after_data: assert property (
        $rose(done_q) && cmd_q == CMD_POLL
        |-> $past(state_q) == ST_REVAL && $past(final_q))
        else $error("poll done without a following data read");
    a_prog_data_addr: assert property (
        (!fl_q.we_n && cmd_q == CMD_PROGRAM && step_q == 3'h3)
        |-> fl_q.addr == addr_q && fl_q.dq == wdata_q)
        else $error("program write not at held address and data");

    c_erase_done: cover property (
        $rose(done_q) && cmd_q == CMD_ERASE);
    c_poll_done: cover property (
        $rose(done_q) && cmd_q == CMD_POLL);
    c_poll_timeout: cover property ($rose(tmo_q));
    c_load_refused: cover property ($rose(ref_q));
endmodule

// ---- pkg/flash_host_pkg.sv ----
// Constants, types and carriers for the parallel flash erase/status host
// Overview of operation
// - Sector erase: unlock, 80H, unlock, 30H
// - Next sector load within 50us window
// - Done: poll bit 6, toggle steady twice
// - Program poll must read program address
// - Erase poll must read selected sector
// - Take data on read after completion
package flash_host_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WDATA  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_RDATA  = 8'h10;

    localparam int ST_BIT_BUSY    = 0;
    localparam int ST_BIT_DONE    = 1;
    localparam int ST_BIT_TIMEOUT = 2;
    localparam int ST_BIT_REFUSED = 3;
    localparam int ST_BIT_READY   = 4;
    localparam int ST_BIT_POLL    = 5;
    localparam int ST_BIT_WINDOW  = 6;

    localparam logic [21:0] ADDR_RST  = 22'h000000;
    localparam logic [15:0] WDATA_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Device command codes and unlock cycles
    // ------------------------------------------------------------------
    localparam logic [21:0] UNLOCK_A1 = 22'h000555;
    localparam logic [21:0] UNLOCK_A2 = 22'h0002aa;
    localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
    localparam logic [15:0] UNLOCK_D2 = 16'h0055;
    localparam logic [15:0] CODE_ERASE_SETUP = 16'h0080;
    localparam logic [15:0] CODE_SECTOR      = 16'h0030;
    localparam logic [15:0] CODE_PROGRAM     = 16'h00a0;
    localparam logic [15:0] CODE_SUSPEND     = 16'h00b0;
    localparam logic [15:0] CODE_RESUME      = 16'h0030;
    localparam logic [15:0] CODE_RESET       = 16'h00f0;

    localparam int DQ_POLL    = 7;
    localparam int DQ_TOGGLE1 = 6;
    localparam int DQ_TIMEOUT = 5;
    localparam int DQ_WINDOW  = 3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SYNC_STAGES     = 2;
    localparam int T_WE_LOW_NS     = 40;
    localparam int T_WE_HIGH_NS    = 30;
    localparam int T_READ_NS       = 100;
    localparam int T_LOAD_WINDOW_US = 50;
    localparam int WE_LOW_CYC  = (T_WE_LOW_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int WE_HIGH_CYC = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int READ_CYC    = (T_READ_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS + SYNC_STAGES;
    localparam int LOAD_WINDOW_CYC = T_LOAD_WINDOW_US * 1000
                                     / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE       = 4'h0,
        CMD_READ       = 4'h1,
        CMD_PROGRAM    = 4'h2,
        CMD_ERASE      = 4'h3,
        CMD_ADD_SECTOR = 4'h4,
        CMD_SUSPEND    = 4'h5,
        CMD_RESUME     = 4'h6,
        CMD_RESET      = 4'h7,
        CMD_POLL       = 4'h8
    } cmd_t;

    typedef struct packed {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [21:0] addr;
        logic [15:0] dq;
        logic        dq_oe;
    } flash_out_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage

// ---- rtl/flash_pin_sync.sv ----
// Two-stage synchroniser for flash input pins
`timescale 1ns/1ns
module flash_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_n,
    // Pins in, synchronised out
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// ---- tb/flash_dev_model.sv ----
// Behavioural flash device: erase, suspend, program and status bits
`timescale 1ns/1ns
module flash_dev_model #(
    parameter int          WIN   = 100,
    parameter int          ERASE = 400,
    parameter logic [15:0] DATA  = 16'h00a5,
    parameter logic [5:0]  PROT  = 6'h3f
) (
    // Clock, stuck-erase control and host pins
    input  wire logic        i_clk_sys,
    input  wire logic        i_stuck,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic [21:0] i_addr,
    input  wire logic [15:0] i_dq,
    // Device drive
    output logic      [15:0] o_dq,
    output logic             o_dq_en,
    output logic             o_busy_low
);
    typedef enum logic [2:0] {RD, LOAD, ERS, SUSP, PRG} mode_t;
    mode_t       mode = RD;
    int          seq  = 0;
    int          tmr  = 0;
    logic [21:0] a_lat;
    logic [21:0] sect = '0;
    logic [7:0]  d;
    logic [7:0]  pd = '0;
    logic        t1 = 0, t2 = 0, tmo = 0;
    wire         wr = i_ce_n | i_we_n;
    wire         rd = i_ce_n | i_oe_n;
    always @(negedge wr) begin
        a_lat = i_addr;
        if (mode == LOAD) tmr = 0;
    end
    always @(posedge wr) begin
        d = i_dq[7:0];
        if (d == 8'hf0 && (mode < ERS || tmo)) begin
            mode = RD;
            seq = 0;
            tmo = 0;
        end else if (mode == LOAD) begin
            tmr = 0;
            if (d != 8'h30) mode = (d == 8'hb0) ? SUSP : RD;
        end else if (mode == ERS && d == 8'hb0 && !tmo) mode = SUSP;
        else if (mode == SUSP && d == 8'h30) mode = ERS;
        else if (mode == RD) begin
            if (seq == 6) begin
                mode = PRG;
                pd = d;
                tmr = (a_lat[21:16] == PROT) ? ERASE / 8 : 0;
                seq = 0;
            end else case (seq)
                0, 3: seq = (d == 8'haa) ? seq + 1 : 0;
                1, 4: seq = (d == 8'h55) ? seq + 1 : 0;
                2: seq = (d == 8'h80) ? 3 : (d == 8'ha0) ? 6 : 0;
                5: seq = (d == 8'h30) ? 7 : 0;
                default: seq = 0;
            endcase
            if (seq == 7) begin
                mode = LOAD;
                sect = a_lat;
                tmr = 0;
                seq = 0;
            end
        end
    end
    always @(posedge i_clk_sys) begin
        if (mode != SUSP) tmr <= tmr + 1;
        if (mode == LOAD && tmr >= WIN) begin
            mode <= ERS;
            tmr <= (sect[21:16] == PROT) ? ERASE / 2 : 0;
        end
        if (mode == ERS && tmr >= ERASE) begin
            tmo <= i_stuck;
            if (!i_stuck) mode <= RD;
        end
        if (mode == PRG && tmr >= ERASE / 4) mode <= RD;
    end
    always @(negedge rd) begin
        if (mode inside {LOAD, ERS, PRG}) t1 = ~t1;
        if (mode inside {LOAD, ERS, SUSP} && i_addr == sect) t2 = ~t2;
    end
    always_comb begin
        case (mode)
            LOAD, ERS: o_dq = {8'h00, 1'b0, t1, tmo, 1'b0, mode == ERS,
                               t2, 2'b00};
            SUSP: o_dq = (i_addr == sect) ?
                         {8'h00, 1'b1, t1, 3'b000, t2, 2'b00} : DATA;
            PRG: o_dq = {8'h00, ~pd[7], t1, 6'h00};
            default: o_dq = DATA;
        endcase
    end
    assign o_dq_en = !rd;
    assign o_busy_low = mode inside {LOAD, ERS, PRG};
endmodule

// ---- tb/flash_erase_host_test.sv ----
// Self-checking bench for the flash erase/status host
`timescale 1ns/1ns
module flash_erase_host_test;
    import flash_host_pkg::*;
    localparam int          WIN = 100;
    localparam logic [21:0] SA  = 22'h010000;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        stuck = 0;
    apb_req_t    req = '0;
    apb_rsp_t    rsp;
    flash_out_t  fl;
    logic [15:0] dev_dq, fdq;
    logic [15:0] last_dq = '0;
    logic        dev_en, dev_busy, err;
    logic [31:0] r;
    int          n_mismatch = 0;
    int          n_tests = 0;
    always #5 clk = ~clk;
    // Released bus shows the inverse of its last level
    assign fdq = fl.dq_oe ? fl.dq : dev_en ? dev_dq : ~last_dq;
    always @(posedge clk) last_dq <= fdq;
    flash_erase_host #(.LOAD_WINDOW(WIN)) flash_erase_host_inst (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_apb(req), .o_apb(rsp),
        .o_flash(fl), .i_flash_dq(fdq), .i_ready_busy_n(!dev_busy));
    flash_dev_model #(.WIN(WIN)) flash_dev_model_inst (
        .i_clk_sys(clk), .i_stuck(stuck), .i_ce_n(fl.ce_n),
        .i_we_n(fl.we_n), .i_oe_n(fl.oe_n), .i_addr(fl.addr),
        .i_dq(fdq), .o_dq(dev_dq), .o_dq_en(dev_en),
        .o_busy_low(dev_busy));
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) break;
        end
        r = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (i == 20) begin
            n_mismatch++;
            $display("ERROR at %0t: no pready", $time);
            end_sim();
        end
    endtask
    task automatic vr(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r & m, e);
    endtask
    // Issue a command and wait until the host is idle again
    task automatic run(input cmd_t c, input logic [21:0] a);
        int i;
        apb(1'b1, OFS_ADDR, {10'h0, a});
        apb(1'b1, OFS_CTRL, {28'h0, c});
        for (i = 0; i < 3000; i++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (r[ST_BIT_BUSY] === 1'b0) break;
        end
        if (i == 3000) begin
            n_mismatch++;
            $display("ERROR at %0t: host stays busy", $time);
            end_sim();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        vr(8'h20, 32'hffffffff, 32'h0);
        chk(32'(err), 32'h1);
        run(CMD_READ, SA);
        vr(OFS_RDATA, 32'hffff, 32'h00a5);
        run(CMD_ERASE, SA);
        run(CMD_READ, SA);
        vr(OFS_RDATA, 32'h88, 32'h0);
        run(CMD_RESET, SA);
        run(CMD_READ, SA);
        vr(OFS_RDATA, 32'hffff, 32'h00a5);
        run(CMD_SUSPEND, SA);
        run(CMD_READ, SA);
        vr(OFS_RDATA, 32'hffff, 32'h00a5);
        run(CMD_ERASE, SA);
        run(CMD_ADD_SECTOR, SA + 22'h8000);
        chk(r & 32'h0e, 32'h02);
        repeat (WIN + 20) @(posedge clk);
        run(CMD_ADD_SECTOR, SA + 22'h10000);
        chk(r & 32'h1e, 32'h08);
        run(CMD_READ, SA);
        vr(OFS_RDATA, 32'h88, 32'h08);
        vr(OFS_STATUS, 32'h60, 32'h40);
        run(CMD_POLL, SA);
        chk(r & 32'h3e, 32'h32);
        vr(OFS_RDATA, 32'hffff, 32'h00a5);
        run(CMD_ERASE, SA);
        run(CMD_SUSPEND, SA);
        run(CMD_POLL, SA);
        chk(r & 32'h3e, 32'h32);
        run(CMD_RESUME, SA);
        run(CMD_SUSPEND, SA);
        run(CMD_READ, SA + 22'h8000);
        vr(OFS_RDATA, 32'hffff, 32'h00a5);
        run(CMD_READ, SA);
        vr(OFS_RDATA, 32'h80, 32'h80);
        run(CMD_RESUME, SA);
        run(CMD_READ, SA);
        vr(OFS_RDATA, 32'h80, 32'h0);
        run(CMD_POLL, SA);
        chk(r & 32'h3e, 32'h32);
        apb(1'b1, OFS_WDATA, 32'h0080);
        run(CMD_PROGRAM, SA + 22'h20000);
        run(CMD_READ, SA + 22'h20000);
        chk(r & 32'h10, 32'h0);
        vr(OFS_RDATA, 32'h80, 32'h0);
        run(CMD_POLL, SA + 22'h20000);
        chk(r & 32'h3e, 32'h32);
        stuck <= 1'b1;
        run(CMD_ERASE, SA);
        run(CMD_POLL, SA);
        chk(r & 32'h06, 32'h04);
        run(CMD_RESET, SA);
        stuck <= 1'b0;
        run(CMD_READ, SA);
        vr(OFS_RDATA, 32'hffff, 32'h00a5);
        end_sim();
    end
endmodule
